//--- src/ssp_top.sv
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module ssp_top (
   // clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // axi4-lite write address
   input  wire logic [ssp_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // axi4-lite read address
   input  wire logic [ssp_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // serial pins
   input  wire logic                      serial_in_pin,
   input  wire logic                      xfer_clock_pin_i,
   output logic                           xfer_clock_pin_o,
   output logic                           xfer_clock_pin_oe,
   output logic                           serial_out_pin_o,
   output logic                           serial_out_pin_oe,
   // interrupt
   output logic                           xfer_done_irq
);
   import ssp_pkg::*;

   typedef enum logic {SSP_IDLE, SSP_RUN} ssp_state_e;

   // ==========================================
   // registers
   ssp_state_e  state;
   logic [3:0]  serial_mode_reg0;
   logic [5:0]  serial_clock_reg1;
   logic [15:0] tx_buf;
   logic [15:0] rx_buf;
   logic        xfer_go;
   logic        done_stat;
   logic        done_en;
   logic [14:0] pin_cfg;
   logic [4:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;

   ssp_shift_if sh ();

   ssp_shifter u_shifter (
      .aclk    (aclk),
      .aresetn (aresetn),
      .s       (sh.shifter)
   );

   // ==========================================
   // mode decode
   wire [1:0] mode_sel_hi_lo = serial_mode_reg0[M0_MODE +: 2];
   wire       mode_stop   = (mode_sel_hi_lo == MODE_STOP);
   wire       mode_rx     = (mode_sel_hi_lo == MODE_RX);
   wire       mode_tx     = (mode_sel_hi_lo == MODE_TX);
   wire       mode_trx    = (mode_sel_hi_lo == MODE_TRX);
   wire       rx_capture  = mode_rx || mode_trx;
   wire       word_len_sel = serial_mode_reg0[M0_LEN];
   wire [3:0] ck_sel      = serial_clock_reg1[C1_CK +: 4];
   wire       clock_phase_type = serial_clock_reg1[C1_CKT];
   wire       clk_neg     = serial_clock_reg1[C1_NEG];
   wire       ext_clk     = (ck_sel == CK_EXT_A) || (ck_sel == CK_EXT_B) ||
                            (ck_sel == CK_EXT_C);
   wire       master      = !ext_clk;

   // ==========================================
   // pin function and direction
   wire [2:0] pin_func_hi    = pin_cfg[PF_HI +: 3];
   wire [2:0] pin_func_lo    = pin_cfg[PF_LO +: 3];
   wire [2:0] pin_drive_cfg1 = pin_cfg[PF_D1 +: 3];
   wire [2:0] pin_drive_cfg0 = pin_cfg[PF_D0 +: 3];
   wire [2:0] pin_direction  = pin_cfg[PF_DIR +: 3];
   wire [2:0] routed   = pin_func_hi & ~pin_func_lo;
   wire [2:0] cmos_out = routed & pin_drive_cfg1 & pin_drive_cfg0 & ~pin_direction;
   wire       sin_ok   = routed[PIN_SIN] && pin_direction[PIN_SIN];
   wire       sck_in_ok = routed[PIN_SCK] && pin_direction[PIN_SCK];

   // ==========================================
   // pin synchronisers
   logic sin_m;
   logic sin_s;
   logic sck_m;
   logic sck_s;
   logic sck_d;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sin_m <= 1'b1;
         sin_s <= 1'b1;
         sck_m <= 1'b0;
         sck_s <= 1'b0;
         sck_d <= 1'b0;
      end else begin
         sin_m <= serial_in_pin;
         sin_s <= sin_m;
         sck_m <= xfer_clock_pin_i;
         sck_s <= sck_m;
         sck_d <= sck_s;
      end
   end

   // slave ignores the clock type; both spi modes sample on the rising edge
   wire sck_lvl  = (sck_s ^ clk_neg) & sck_in_ok;
   wire sck_lvlq = (sck_d ^ clk_neg) & sck_in_ok;
   wire ext_rise = sck_lvl && !sck_lvlq;
   wire ext_fall = !sck_lvl && sck_lvlq;

   // ==========================================
   // master clock divider
   logic [15:0] div_cnt;
   logic [5:0]  tgl_cnt;
   logic        sck_int;

   wire [2:0]  div_shift = ck_sel[3] ? {2'b00, ck_sel[0]} : ck_sel[2:0];
   wire [15:0] half      = DIV_BASE << div_shift;
   wire        running   = (state == SSP_RUN);
   wire        half_tick = running && master && (div_cnt == half - 16'h0001);
   wire [5:0]  tgl_total = {1'b0, (word_len_sel ? BITS_LONG : BITS_SHORT)} << 1;
   wire        int_rise  = half_tick && !sck_int;
   wire        int_fall  = half_tick && sck_int;
   wire        idle_lvl  = !clock_phase_type;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= 16'h0000;
         tgl_cnt <= 6'h00;
         sck_int <= 1'b1;
      end else if (!running) begin
         div_cnt <= 16'h0000;
         tgl_cnt <= 6'h00;
         sck_int <= idle_lvl;
      end else if (half_tick) begin
         div_cnt <= 16'h0000;
         tgl_cnt <= tgl_cnt + 6'h01;
         sck_int <= !sck_int;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // ==========================================
   // transfer sequencing
   wire start_x  = (state == SSP_IDLE) && xfer_go && !mode_stop;
   // master ends on the last edge so the clock is back at its idle level
   wire end_m    = master && (tgl_cnt == tgl_total);
   wire end_s    = !master && sh.full;
   wire hw_done  = running && (end_m || end_s);

   assign sh.start     = start_x;
   assign sh.sample    = running && (master ? int_rise : ext_rise);
   assign sh.shift     = running && (master ? int_fall : ext_fall);
   assign sh.len16     = word_len_sel;
   assign sh.msb_first = serial_mode_reg0[M0_DIR];
   assign sh.sin       = sin_ok ? sin_s : 1'b1;
   assign sh.tx_word   = tx_buf;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= SSP_IDLE;
      end else begin
         case (state)
            SSP_IDLE: begin
               if (start_x) begin
                  state <= SSP_RUN;
               end
            end
            SSP_RUN: begin
               // software clearing go aborts the word
               if (hw_done || !xfer_go || mode_stop) begin
                  state <= SSP_IDLE;
               end
            end
            default: begin
               state <= SSP_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // axi4-lite write channel
   wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire [4:0]  wa = {wr_addr[4:2], 2'b00};
   wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire wr_mode0 = wr_fire && (wa == OFS_MODE0);
   wire wr_clk1  = wr_fire && (wa == OFS_CLK1);
   wire wr_buf   = wr_fire && (wa == OFS_BUF);
   wire wr_ctrl  = wr_fire && (wa == OFS_CTRL) && wr_strb[0];
   wire wr_ien   = wr_fire && (wa == OFS_IEN);
   wire wr_iclr  = wr_fire && (wa == OFS_ICLR) && wr_strb[0];
   wire wr_pin   = wr_fire && (wa == OFS_PIN);
   wire wr_hit   = wr_mode0 || wr_clk1 || wr_buf || (wa == OFS_CTRL) || wr_ien ||
                   (wa == OFS_ICLR) || wr_pin || (wa == OFS_STAT);
   wire [31:0] m_mode0 = ({28'h0000000, serial_mode_reg0} & ~wmask) | (wr_data & wmask);
   wire [31:0] m_clk1  = ({26'h0, serial_clock_reg1} & ~wmask) | (wr_data & wmask);
   wire [31:0] m_buf   = ({16'h0000, tx_buf} & ~wmask) | (wr_data & wmask);
   wire [31:0] m_pin   = ({17'h0, pin_cfg} & ~wmask) | (wr_data & wmask);
   wire        next_done = hw_done || (done_stat && !(wr_iclr && wr_data[ST_DONE]));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         wr_addr       <= 5'h00;
         wr_data       <= 32'h00000000;
         wr_strb       <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wr_addr       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ==========================================
   // register file
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_mode_reg0  <= MODE0_RST;
         serial_clock_reg1 <= CLK1_RST;
         tx_buf            <= 16'h0000;
         pin_cfg           <= PIN_RST;
         done_en           <= 1'b0;
      end else begin
         if (wr_mode0) begin
            serial_mode_reg0 <= m_mode0[3:0];
         end
         if (wr_clk1) begin
            serial_clock_reg1 <= m_clk1[5:0];
         end
         if (wr_buf) begin
            tx_buf <= m_buf[15:0];
         end
         if (wr_pin) begin
            pin_cfg <= m_pin[14:0];
         end
         if (wr_ien && wr_strb[0]) begin
            done_en <= wr_data[ST_DONE];
         end
      end
   end

   // go clears itself at the end of a word; a stopped port refuses it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xfer_go   <= 1'b0;
         done_stat <= 1'b0;
         rx_buf    <= 16'h0000;
         xfer_done_irq <= 1'b0;
      end else begin
         if (hw_done) begin
            xfer_go <= 1'b0;
         end else if (wr_ctrl) begin
            xfer_go <= wr_data[CTRL_GO] && !mode_stop;
         end
         if (hw_done && rx_capture) begin
            rx_buf <= sh.rx_word;
         end
         done_stat     <= next_done;
         xfer_done_irq <= next_done && done_en;
      end
   end

   // ==========================================
   // axi4-lite read channel
   wire [4:0]  ra = {s_axi_araddr[4:2], 2'b00};
   wire        rd_hit = (ra == OFS_MODE0) || (ra == OFS_CLK1) || (ra == OFS_BUF) ||
                        (ra == OFS_CTRL) || (ra == OFS_STAT) || (ra == OFS_IEN) ||
                        (ra == OFS_ICLR) || (ra == OFS_PIN);
   wire [31:0] rd_data =
      (ra == OFS_MODE0) ? {28'h0000000, serial_mode_reg0} :
      (ra == OFS_CLK1)  ? {26'h0, serial_clock_reg1} :
      (ra == OFS_BUF)   ? {16'h0000, rx_buf} :
      (ra == OFS_CTRL)  ? {31'h0, xfer_go} :
      (ra == OFS_STAT)  ? {31'h0, done_stat} :
      (ra == OFS_IEN)   ? {31'h0, done_en} :
      (ra == OFS_PIN)   ? {17'h0, pin_cfg} : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================
   // pin drivers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_out_pin_o  <= 1'b1;
         serial_out_pin_oe <= 1'b0;
         xfer_clock_pin_o  <= 1'b1;
         xfer_clock_pin_oe <= 1'b0;
      end else begin
         serial_out_pin_o  <= (mode_rx || mode_stop) ? 1'b1 : sh.tx_bit;
         serial_out_pin_oe <= cmos_out[PIN_SOUT];
         xfer_clock_pin_o  <= sck_int ^ clk_neg;
         xfer_clock_pin_oe <= master && cmos_out[PIN_SCK];
      end
   end
endmodule // ssp_top

//--- src/ssp_pkg.sv
package ssp_pkg;
   // ==========================================
   // bus geometry and register offsets
   localparam int         AXI_AW      = 5;
   localparam logic [4:0] OFS_MODE0   = 5'h00;
   localparam logic [4:0] OFS_CLK1    = 5'h04;
   localparam logic [4:0] OFS_BUF     = 5'h08;
   localparam logic [4:0] OFS_CTRL    = 5'h0C;
   localparam logic [4:0] OFS_STAT    = 5'h10;
   localparam logic [4:0] OFS_IEN     = 5'h14;
   localparam logic [4:0] OFS_ICLR    = 5'h18;
   localparam logic [4:0] OFS_PIN     = 5'h1C;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================
   // serial_mode_reg0 fields
   localparam int         M0_DIR      = 0;
   localparam int         M0_MODE     = 1;
   localparam int         M0_LEN      = 3;
   localparam logic [3:0] MODE0_RST   = 4'h0;
   localparam logic [1:0] MODE_STOP   = 2'h0;
   localparam logic [1:0] MODE_RX     = 2'h1;
   localparam logic [1:0] MODE_TX     = 2'h2;
   localparam logic [1:0] MODE_TRX    = 2'h3;
   // ==========================================
   // serial_clock_reg1 fields
   localparam int         C1_CK       = 0;
   localparam int         C1_CKT      = 4;
   localparam int         C1_NEG      = 5;
   localparam logic [5:0] CLK1_RST    = 6'h00;
   localparam logic [3:0] CK_EXT_A    = 4'h6;
   localparam logic [3:0] CK_EXT_B    = 4'h7;
   localparam logic [3:0] CK_EXT_C    = 4'hE;
   // ==========================================
   // control, status and pin configuration fields
   localparam int          CTRL_GO    = 0;
   localparam int          ST_DONE    = 0;
   localparam int          PF_HI      = 0;
   localparam int          PF_LO      = 3;
   localparam int          PF_D1      = 6;
   localparam int          PF_D0      = 9;
   localparam int          PF_DIR     = 12;
   localparam int          PIN_SOUT   = 0;
   localparam int          PIN_SCK    = 1;
   localparam int          PIN_SIN    = 2;
   localparam logic [14:0] PIN_RST    = 15'h0000;
   // ==========================================
   // word lengths and divider
   localparam logic [4:0]  BITS_SHORT = 5'h08;
   localparam logic [4:0]  BITS_LONG  = 5'h10;
   localparam logic [15:0] DIV_BASE   = 16'h0004;
endpackage

//--- src/ssp_shift_if.sv
`timescale 1ns/1ps
interface ssp_shift_if;
   logic        start;
   logic        sample;
   logic        shift;
   logic        len16;
   logic        msb_first;
   logic        sin;
   logic [15:0] tx_word;
   logic        tx_bit;
   logic [15:0] rx_word;
   logic        full;
   modport ctrl (output start, sample, shift, len16, msb_first, sin, tx_word,
                 input tx_bit, rx_word, full);
   modport shifter (input start, sample, shift, len16, msb_first, sin, tx_word,
                    output tx_bit, rx_word, full);
endinterface

//--- src/ssp_shifter.sv
`timescale 1ns/1ps
module ssp_shifter (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control side
   ssp_shift_if.shifter s
);
   import ssp_pkg::*;

   logic [15:0] tx_sr;
   logic [15:0] rx_sr;
   logic [4:0]  cnt;

   wire [4:0] nbits   = s.len16 ? BITS_LONG : BITS_SHORT;
   wire [3:0] top_idx = s.len16 ? 4'hF : 4'h7;
   wire       take    = s.sample && (cnt != nbits);

   // ==========================================
   // shift registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_sr <= 16'h0000;
         rx_sr <= 16'h0000;
         cnt   <= 5'h00;
      end else if (s.start) begin
         tx_sr <= s.tx_word;
         rx_sr <= 16'h0000;
         cnt   <= 5'h00;
      end else begin
         if (take) begin
            rx_sr <= s.msb_first ? {rx_sr[14:0], s.sin} : {s.sin, rx_sr[15:1]};
            cnt   <= cnt + 5'h01;
         end
         // no advance before the first sample: mode 3 leads with a falling edge
         if (s.shift && cnt != 5'h00) begin
            tx_sr <= s.msb_first ? {tx_sr[14:0], 1'b1} : {1'b1, tx_sr[15:1]};
         end
      end
   end

   assign s.tx_bit  = s.msb_first ? tx_sr[top_idx] : tx_sr[0];
   assign s.full    = (cnt == nbits);
   // an lsb-first byte lands in the upper half of the register
   assign s.rx_word = s.len16 ? rx_sr :
                      s.msb_first ? {8'h00, rx_sr[7:0]} : {8'h00, rx_sr[15:8]};
endmodule // ssp_shifter

//--- bench/ssp_partner.sv
`timescale 1ns/1ps
module ssp_partner (
   // wires as seen at the pins
   input  wire logic sck,
   input  wire logic sout,
   // lines this model drives
   output logic      p_sck,
   output logic      sin
);
   logic [15:0] word;
   logic [15:0] got;
   logic        msb;
   int          n;
   int          cnt;
   initial begin
      p_sck = 1'h1;
      sin = 1'h0;
      word = '0;
      got = '0;
      msb = 1'h0;
      n = 0;
      cnt = 0;
   end
   function automatic logic pick(input int i);
      return msb ? word[n-1-i] : word[i];
   endfunction
   task automatic load(input logic [15:0] w, input logic m, input int bits);
      word = w;
      msb = m;
      n = bits;
      cnt = 0;
      got = '0;
      sin = pick(0);
   endtask
   // clock stands high between frames, one bit per period
   task automatic drive(input int bits);
      // keep pin edges off the sampling clock edge
      #2;
      repeat (bits) begin
         #40 p_sck = 1'h0;
         #40 p_sck = 1'h1;
      end
   endtask
   always @(posedge sck) begin
      if (cnt < n) begin
         if (msb) got = {got[14:0], sout};
         else got[cnt] = sout;
         cnt = cnt + 1;
         // hold time over: the line no longer shows the last bit
         if (cnt == n) #20 sin = ~sin;
      end
   end
   always @(negedge sck) begin
      if (cnt < n) sin = pick(cnt);
   end
endmodule // ssp_partner

//--- bench/ssp_top_sva.sv
`timescale 1ns/1ps
module ssp_top_sva (
   // clock and reset
   input wire logic                       aclk,
   input wire logic                       aresetn,
   // axi4-lite
   input wire logic [ssp_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic                       s_axi_awvalid,
   input wire logic                       s_axi_awready,
   input wire logic [31:0]                s_axi_wdata,
   input wire logic                       s_axi_wvalid,
   input wire logic                       s_axi_wready,
   input wire logic [1:0]                 s_axi_bresp,
   input wire logic                       s_axi_bvalid,
   input wire logic                       s_axi_bready,
   input wire logic                       s_axi_arvalid,
   input wire logic                       s_axi_arready,
   input wire logic                       s_axi_rvalid,
   // pins and interrupt
   input wire logic                       xfer_clock_pin_o,
   input wire logic                       xfer_clock_pin_oe,
   input wire logic                       serial_out_pin_o,
   input wire logic                       serial_out_pin_oe,
   input wire logic                       xfer_done_irq
);
   import ssp_pkg::*;
   // ==========================================
   // shadow of committed writes
   logic [4:0]  aw_q;
   logic [31:0] w_q;
   logic [1:0]  mode_q;
   logic [3:0]  ck_q;
   logic        ien_q;
   logic [14:0] pin_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= '0;
         w_q <= '0;
         mode_q <= MODE_STOP;
         ck_q <= '0;
         ien_q <= 1'h0;
         pin_q <= PIN_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
         if (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY) begin
            if (aw_q == OFS_MODE0) mode_q <= w_q[M0_MODE+:2];
            if (aw_q == OFS_CLK1) ck_q <= w_q[3:0];
            if (aw_q == OFS_IEN) ien_q <= w_q[0];
            if (aw_q == OFS_PIN) pin_q <= w_q[14:0];
         end
      end
   end
   // shadow lags the design while a write is in flight, so only judge when quiet
   wire quiet = s_axi_awready && s_axi_wready && !s_axi_bvalid;
   wire int_ck = !(ck_q == CK_EXT_A || ck_q == CK_EXT_B || ck_q == CK_EXT_C);
   wire sout_cfg = pin_q[PF_HI+PIN_SOUT] && !pin_q[PF_LO+PIN_SOUT] && pin_q[PF_D1+PIN_SOUT]
                   && pin_q[PF_D0+PIN_SOUT] && !pin_q[PF_DIR+PIN_SOUT];
   wire sck_cfg = pin_q[PF_HI+PIN_SCK] && !pin_q[PF_LO+PIN_SCK] && pin_q[PF_D1+PIN_SCK]
                  && pin_q[PF_D0+PIN_SCK] && !pin_q[PF_DIR+PIN_SCK];
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================
   // assertions
   a_rx_sout_high: assert property (quiet && mode_q == MODE_RX |-> serial_out_pin_o)
      else $error("data output not high in receive mode");
   a_sout_oe_cfg: assert property (serial_out_pin_oe && quiet |-> sout_cfg)
      else $error("data output driven without routing");
   a_sck_oe_cfg: assert property (xfer_clock_pin_oe && quiet |-> sck_cfg && int_ck)
      else $error("clock driven while slave or unrouted");
   a_half_period: assert property (xfer_clock_pin_oe && $changed(xfer_clock_pin_o)
      |=> $stable(xfer_clock_pin_o) [*3])
      else $error("transfer clock half period too short");
   a_stop_still: assert property (quiet && mode_q == MODE_STOP |-> $stable(xfer_clock_pin_o))
      else $error("clock moves while stopped");
   a_irq_masked: assert property (quiet && !ien_q |-> !xfer_done_irq)
      else $error("interrupt high while disabled");
   a_irq_clear: assert property (s_axi_bvalid && s_axi_bready && aw_q == OFS_ICLR
      && w_q[ST_DONE] |=> !xfer_done_irq)
      else $error("interrupt still high after clear");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
endmodule // ssp_top_sva

bind ssp_top ssp_top_sva u_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .xfer_clock_pin_o,
   .xfer_clock_pin_oe, .serial_out_pin_o, .serial_out_pin_oe, .xfer_done_irq);

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import ssp_pkg::*;
   // ==========================================
   // signals and scenario table
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, sout_o, sout_oe;
   logic        irq, p_sck, p_sin;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp;
   logic [15:0] mask, tw, pw;
   int          err_count, checks_done, n;
   wire         sck_w = sck_oe ? sck_o : p_sck;
   wire         sout_w = sout_oe ? sout_o : ~sout_o;
   logic [3:0]  m0 [5] = '{4'h4, 4'hB, 4'hE, 4'h7, 4'h6};
   logic [5:0]  ck [5] = '{6'h00, 6'h01, 6'h10, 6'h00, 6'h06};
   logic [14:0] pin [5] = '{15'h46C7, 15'h46C7, 15'h46C7, 15'h46C7, 15'h6247};
   logic        ien [5] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1};
   logic [4:0]  ra [4] = '{OFS_MODE0, OFS_CLK1, OFS_PIN, OFS_STAT};
   logic [31:0] rv [4] = '{32'(MODE0_RST), 32'(CLK1_RST), 32'(PIN_RST), 32'h0};
   ssp_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .serial_in_pin(p_sin), .xfer_clock_pin_i(sck_w),
      .xfer_clock_pin_o(sck_o), .xfer_clock_pin_oe(sck_oe), .serial_out_pin_o(sout_o),
      .serial_out_pin_oe(sout_oe), .xfer_done_irq(irq));
   ssp_partner p (.sck(sck_w), .sout(sout_w), .p_sck(p_sck), .sin(p_sin));
   initial begin
      aclk = 1'h0;
      forever #4 aclk = ~aclk;
   end
   // ==========================================
   // bus tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      // waits as long as the slave needs; only the watchdog ends a hang
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk("bresp", 32'(RESP_OKAY), 32'(bresp));
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      v = rdata;
      rready <= 1'h0;
      chk("rresp", 32'(RESP_OKAY), 32'(rresp));
   endtask
   task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(nm, e, v);
   endtask
   task automatic results;
      if (err_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      aresetn = 1'h0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      err_count = 0;
      checks_done = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      for (int r = 0; r < 4; r++) rchk("reset", ra[r], rv[r]);
      for (int i = 0; i < 5; i++) begin
         n = m0[i][M0_LEN] ? 16 : 8;
         mask = (n == 16) ? 16'hFFFF : 16'h00FF;
         tw = 16'hA5C3 + 16'(i);
         pw = 16'h5A3C - 16'(i);
         wr(OFS_PIN, 32'(pin[i]));
         wr(OFS_CLK1, 32'(ck[i]));
         wr(OFS_IEN, 32'(ien[i]));
         wr(OFS_MODE0, 32'(m0[i]));
         wr(OFS_BUF, 32'(tw));
         if (i < 4) chk("sck_idle", 32'(!ck[i][C1_CKT]), 32'(sck_w));
         p.load(pw, m0[i][M0_DIR], n);
         wr(OFS_CTRL, 32'h1);
         if (i == 4) p.drive(n);
         for (int k = 0; k < 300; k++) begin
            rd(OFS_STAT, d);
            if (d[ST_DONE] === 1'h1) break;
         end
         chk("irq", 32'(ien[i]), 32'(irq));
         rchk("go", OFS_CTRL, 32'h0);
         chk("bits", 32'(n), 32'(p.cnt));
         chk("tx", 32'(m0[i][2] ? tw & mask : mask), 32'(p.got));
         if (m0[i][1]) rchk("rx", OFS_BUF, 32'(pw & mask));
         wr(OFS_ICLR, 32'h1);
         rchk("stat", OFS_STAT, 32'h0);
         chk("irq_clr", 32'h0, 32'(irq));
      end
      wr(OFS_MODE0, 32'(MODE_STOP));
      p.load(16'h0F0F, 1'h0, 8);
      wr(OFS_CTRL, 32'h1);
      repeat (40) @(posedge aclk);
      rchk("stop_go", OFS_CTRL, 32'h0);
      rchk("stop_stat", OFS_STAT, 32'h0);
      chk("stop_bits", 32'h0, 32'(p.cnt));
      results();
   end
   // whole run is under a thousand cycles
   initial begin
      #200000;
      err_count++;
      results();
   end
endmodule // tb_top
